// File: fsn_pkg.sv
/*
  constants, types and helper functions of the special-value and nan handler
  assumes single precision operands and half precision only on conversions
*/
// Summary of operation
// - infinity is maximum biased exponent with zero fraction, 255 in single
// - compares are affine: -inf below every finite value, +inf above
// - results involving infinities are exact, never inexact
// - infinite operand raises invalid only when its use is invalid
// - overflow may deliver a signed infinity
// - maximum exponent with nonzero fraction is a nan, sign ignored
// - nan with top fraction bit set is quiet, clear is signaling
// - quiet nans pass most arithmetic without raising anything
// - signaling nan operand raises invalid
// - a signaling nan is never produced as a result
// - unmasked signaling source: signal exception, destination not written
// - quieting sets the top fraction bit, other bits kept
// - masked: set invalid flag on signaling source, deliver quiet result
// - invalid without nan sources returns the indefinite
// - snan plus qnan: legacy returns qnan, vector returns first quieted
// - two snans: legacy larger significand quieted, vector first quieted
// - two qnans: legacy larger significand, vector first unchanged
// - nan with ordinary value returns the nan, quieted if signaling
// - one-operand nan returns the operand, quieted if signaling
// - one reserved quiet indefinite encoding returned on masked invalid
// - no arithmetic on half precision, only conversions to and from single
// - single exponent 1 to 254 is normal, zero exponent zero or denormal
// - mask set gives default result, mask clear requests a handler
package fsn_pkg;

  localparam int SP_EXP_W  = 8;
  localparam int SP_FRAC_W = 23;
  localparam int SP_W      = 32;
  localparam int HP_EXP_W  = 5;
  localparam int HP_FRAC_W = 10;
  localparam int HP_W      = 16;
  localparam int SP_QBIT   = 22;
  localparam int HP_QBIT   = 9;
  localparam int HP_SHIFT  = 13;  // fraction gap between single and half
  localparam logic [31:0] SP_INDEF_DEF = 32'hffc00000;
  localparam logic [7:0]  SP_EXP_MAX   = 8'hff;
  localparam logic [4:0]  HP_EXP_MAX   = 5'h1f;

  // operation codes
  typedef enum logic [2:0] {
    FSN_OP_ADD  = 3'h0,
    FSN_OP_SUB  = 3'h1,
    FSN_OP_MUL  = 3'h3,
    FSN_OP_DIV  = 3'h2,
    FSN_OP_SQRT = 3'h6,
    FSN_OP_CMP  = 3'h7,
    FSN_OP_H2S  = 3'h5,
    FSN_OP_S2H  = 3'h4
  } fsn_op_t;

  // propagation style
  typedef enum logic {
    FSN_LEGACY = 1'b0,
    FSN_VECTOR = 1'b1
  } fsn_style_t;

  // compare outcome
  typedef enum logic [1:0] {
    FSN_EQ = 2'h0,
    FSN_LT = 2'h1,
    FSN_GT = 2'h2,
    FSN_UN = 2'h3
  } fsn_cmp_t;

  typedef struct packed {
    logic sign;
    logic zero;
    logic denorm;
    logic norm;
    logic inf;
    logic nan;
    logic snan;
  } fsn_class_t;

  typedef struct packed {
    fsn_op_t     op;
    fsn_style_t  style;
    logic        invalid_mask;
    logic        ovf;           // core overflow, ordinary operands
    logic        core_inexact;  // core rounding result
    logic [31:0] a;
    logic [31:0] b;
  } fsn_req_t;

  typedef struct packed {
    logic [31:0] result;
    logic        special;        // result decided here
    fsn_cmp_t    cmp;
    logic        invalid_flag;
    logic        trap;           // software handler request
    logic        store_suppress;
    logic        inexact;
  } fsn_rsp_t;

  // set the quiet bit, keep the rest
  function automatic logic [31:0] fsn_quiet_sp(input logic [31:0] v);
    fsn_quiet_sp = v | (32'h1 << SP_QBIT);
  endfunction : fsn_quiet_sp

  function automatic logic [15:0] fsn_quiet_hp(input logic [15:0] v);
    fsn_quiet_hp = v | (16'h1 << HP_QBIT);
  endfunction : fsn_quiet_hp

endpackage : fsn_pkg

// File: fsn_classify.sv
/*
  operand classifier for any binary interchange width
  assumes a plain combinational use, no clock
*/
`timescale 1ns/1ns
`default_nettype none
module fsn_classify #(
  parameter int EW = 8,
  parameter int FW = 23
) (
  input  wire logic [EW+FW:0]    value,
  output fsn_pkg::fsn_class_t    cls
);
  import fsn_pkg::*;

  logic [EW-1:0] expo;
  logic [FW-1:0] frac;
  logic          e_max;
  logic          e_zero;

  // field split and exponent extremes
  assign expo   = value[EW+FW-1:FW];
  assign frac   = value[FW-1:0];
  assign e_max  = &expo;
  assign e_zero = ~|expo;

  // class flags
  assign cls.sign   = value[EW+FW];
  assign cls.zero   = e_zero & ~|frac;
  assign cls.denorm = e_zero & |frac;
  assign cls.norm   = ~e_zero & ~e_max;
  assign cls.inf    = e_max & ~|frac;
  assign cls.nan    = e_max & |frac;
  assign cls.snan   = e_max & |frac & ~frac[FW-1];

endmodule : fsn_classify
`default_nettype wire

// File: fsn_pick.sv
/*
  nan propagation selector for two-source and one-source operations
  assumes at least one source is a nan when its output is used
*/
`timescale 1ns/1ns
`default_nettype none
module fsn_pick (
  input  wire logic [31:0]         a,
  input  wire logic [31:0]         b,
  input  wire fsn_pkg::fsn_class_t cls_a,
  input  wire fsn_pkg::fsn_class_t cls_b,
  input  wire fsn_pkg::fsn_style_t style,
  input  wire logic                unary,
  output logic [31:0]              pick
);
  import fsn_pkg::*;

  logic b_larger;

  // legacy tie keeps the first source
  assign b_larger = b[SP_FRAC_W-1:0] > a[SP_FRAC_W-1:0];

  // propagation choice
  always_comb begin
    if (unary || !cls_b.nan) begin
      pick = fsn_quiet_sp(a);
    end else if (!cls_a.nan) begin
      pick = fsn_quiet_sp(b);
    end else if (style == FSN_VECTOR) begin
      pick = fsn_quiet_sp(a);
    end else if (cls_a.snan != cls_b.snan) begin
      pick = cls_a.snan ? b : a;
    end else begin
      pick = fsn_quiet_sp(b_larger ? b : a);
    end
  end

endmodule : fsn_pick
`default_nettype wire

// File: fsn_handler.sv
/*
  special-value and nan handler: classifies operands, decides results
  involving infinities and nans, raises invalid and store-suppress
  assumes the pipeline presents one request per cycle with req_valid
*/
`timescale 1ns/1ns
`default_nettype none
module fsn_handler #(
  parameter logic [31:0] INDEF_VALUE = fsn_pkg::SP_INDEF_DEF
) (
  input  wire logic              mclk,
  input  wire logic              sys_rst,
  input  wire logic              req_valid,
  input  wire fsn_pkg::fsn_req_t req,
  output logic                   rsp_valid,
  output fsn_pkg::fsn_rsp_t      rsp
);
  import fsn_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // classification

  fsn_class_t  cls_a;
  fsn_class_t  cls_b;
  fsn_class_t  cls_h;
  logic [31:0] pick;
  logic        unary;
  logic        cvt;
  logic        b_sign;

  assign unary  = (req.op == FSN_OP_SQRT);
  assign cvt    = (req.op == FSN_OP_H2S) || (req.op == FSN_OP_S2H);
  assign b_sign = req.b[SP_W-1] ^ (req.op == FSN_OP_SUB);

  fsn_classify #(.EW(SP_EXP_W), .FW(SP_FRAC_W)) u_cls_a (
    .value (req.a),
    .cls   (cls_a)
  );

  fsn_classify #(.EW(SP_EXP_W), .FW(SP_FRAC_W)) u_cls_b (
    .value (req.b),
    .cls   (cls_b)
  );

  // half operand only seen by conversions
  fsn_classify #(.EW(HP_EXP_W), .FW(HP_FRAC_W)) u_cls_h (
    .value (req.a[HP_W-1:0]),
    .cls   (cls_h)
  );

  fsn_pick u_pick (
    .a     (req.a),
    .b     (req.b),
    .cls_a (cls_a),
    .cls_b (cls_b),
    .style (req.style),
    .unary (unary),
    .pick  (pick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // affine compare of sign-magnitude values

  function automatic fsn_cmp_t fsn_order(input logic [31:0] x, input logic [31:0] y,
                                         input logic xz, input logic yz);
    logic [30:0] mx;
    logic [30:0] my;
    mx = x[30:0];
    my = y[30:0];
    if (xz && yz) begin
      fsn_order = FSN_EQ;
    end else if (x[31] != y[31]) begin
      fsn_order = x[31] ? FSN_LT : FSN_GT;
    end else if (mx == my) begin
      fsn_order = FSN_EQ;
    end else begin
      fsn_order = ((mx > my) ^ x[31]) ? FSN_GT : FSN_LT;
    end
  endfunction : fsn_order

  ////////////////////////////////////////////////////////////////////////////
  // invalid detection

  logic nan_any;
  logic snan_any;
  logic inv_op;
  logic invalid;
  logic inf_any;

  // half arithmetic is never decoded; conversions look at one format only
  always_comb begin
    if (req.op == FSN_OP_H2S) begin
      nan_any  = cls_h.nan;
      snan_any = cls_h.snan;
      inf_any  = cls_h.inf;
    end else if (req.op == FSN_OP_S2H || unary) begin
      nan_any  = cls_a.nan;
      snan_any = cls_a.snan;
      inf_any  = cls_a.inf;
    end else begin
      nan_any  = cls_a.nan | cls_b.nan;
      snan_any = cls_a.snan | cls_b.snan;
      inf_any  = cls_a.inf | cls_b.inf;
    end
  end

  // operations made invalid by their operand values alone
  always_comb begin
    unique case (req.op)
      FSN_OP_ADD, FSN_OP_SUB: inv_op = cls_a.inf & cls_b.inf & (cls_a.sign != b_sign);
      FSN_OP_MUL:  inv_op = (cls_a.inf & cls_b.zero) | (cls_a.zero & cls_b.inf);
      FSN_OP_DIV:  inv_op = (cls_a.inf & cls_b.inf) | (cls_a.zero & cls_b.zero);
      FSN_OP_SQRT: inv_op = cls_a.sign & ~cls_a.zero;
      FSN_OP_CMP, FSN_OP_H2S, FSN_OP_S2H: inv_op = 1'b0;
    endcase
  end

  // quiet nans never raise anything
  assign invalid = snan_any | (inv_op & ~nan_any);

  ////////////////////////////////////////////////////////////////////////////
  // result selection

  logic [31:0] next_result;
  logic        next_special;
  fsn_cmp_t    next_cmp;

  always_comb begin
    next_result  = '0;
    next_special = 1'b1;
    next_cmp     = FSN_UN;
    if (req.op == FSN_OP_CMP) begin
      next_special = nan_any | inf_any;
      next_cmp     = nan_any ? FSN_UN : fsn_order(req.a, req.b, cls_a.zero, cls_b.zero);
    end else if (req.op == FSN_OP_H2S) begin
      // widen half nan or infinity, payload moved up
      next_special = nan_any | inf_any;
      next_result  = {req.a[HP_W-1], SP_EXP_MAX,
                      req.a[HP_FRAC_W-1:0], {HP_SHIFT{1'b0}}};
      if (cls_h.nan) begin
        next_result = fsn_quiet_sp(next_result);
      end
    end else if (req.op == FSN_OP_S2H) begin
      // narrow, upper payload bits kept
      next_special = nan_any | inf_any;
      next_result  = {16'h0000, fsn_quiet_hp({req.a[SP_W-1], HP_EXP_MAX,
                                             req.a[SP_FRAC_W-1:HP_SHIFT]})};
      if (cls_a.inf) begin
        next_result = {16'h0000, req.a[SP_W-1], HP_EXP_MAX, {HP_FRAC_W{1'b0}}};
      end
    end else if (nan_any) begin
      next_result = pick;
    end else if (inv_op) begin
      next_result = INDEF_VALUE;
    end else if (inf_any) begin
      unique case (req.op)
        FSN_OP_ADD, FSN_OP_SUB: begin
          next_result = cls_a.inf ? req.a : {b_sign, req.b[30:0]};
        end
        FSN_OP_MUL: begin
          next_result = {req.a[31] ^ req.b[31], SP_EXP_MAX, {SP_FRAC_W{1'b0}}};
        end
        FSN_OP_DIV: begin
          next_result = {req.a[31] ^ req.b[31],
                         cls_a.inf ? SP_EXP_MAX : 8'h00, {SP_FRAC_W{1'b0}}};
        end
        default: begin
          next_result = req.a;                   // square root of +inf
        end
      endcase
    end else if (req.ovf) begin
      next_result = {req.a[31] ^ (req.op == FSN_OP_MUL || req.op == FSN_OP_DIV ?
                     req.b[31] : 1'b0), SP_EXP_MAX, {SP_FRAC_W{1'b0}}};
    end else begin
      next_special = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // response registers

  // valid stage
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= req_valid;
    end
  end

  // result and flags, flags only for taken requests
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rsp <= '0;
    end else begin
      rsp.result         <= next_result;
      rsp.special        <= req_valid & next_special;
      rsp.cmp            <= next_cmp;
      rsp.invalid_flag   <= req_valid & invalid;
      rsp.trap           <= req_valid & invalid & ~req.invalid_mask;
      rsp.store_suppress <= req_valid & invalid & ~req.invalid_mask;
      rsp.inexact        <= req_valid & req.core_inexact & ~next_special;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  logic mask_q;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mask_q <= 1'b0;
    end else begin
      mask_q <= req.invalid_mask;
    end
  end

  chk_special_exact: assert property (@(posedge mclk) disable iff (sys_rst)
    rsp_valid && rsp.special |-> !rsp.inexact)
    else $error("inexact raised on a special result");

  chk_snan_flag: assert property (@(posedge mclk) disable iff (sys_rst)
    req_valid && !cvt && cls_a.snan |=> rsp.invalid_flag)
    else $error("signaling operand did not raise invalid");

  chk_qnan_silent: assert property (@(posedge mclk) disable iff (sys_rst)
    req_valid && !cvt && cls_a.nan && !cls_a.snan && !cls_b.snan |=> !rsp.invalid_flag)
    else $error("quiet nan raised invalid");

  chk_no_snan_out: assert property (@(posedge mclk) disable iff (sys_rst)
    rsp_valid && rsp.special && &rsp.result[30:23] && |rsp.result[22:0]
    |-> rsp.result[SP_QBIT])
    else $error("signaling nan produced");

  chk_suppress_unmask: assert property (@(posedge mclk) disable iff (sys_rst)
    rsp_valid |-> rsp.store_suppress == (rsp.invalid_flag && !mask_q))
    else $error("store suppress does not follow unmasked invalid");

  chk_vector_first: assert property (@(posedge mclk) disable iff (sys_rst)
    req_valid && req.style == FSN_VECTOR && !cvt && req.op != FSN_OP_CMP
    && cls_a.nan && cls_b.nan |=> rsp.result == fsn_quiet_sp($past(req.a)))
    else $error("vector style did not return first source");

  chk_legacy_qnan: assert property (@(posedge mclk) disable iff (sys_rst)
    req_valid && req.style == FSN_LEGACY && req.op == FSN_OP_ADD
    && cls_a.snan && cls_b.nan && !cls_b.snan |=> rsp.result == $past(req.b))
    else $error("legacy style did not return quiet source");

  chk_inf_order: assert property (@(posedge mclk) disable iff (sys_rst)
    req_valid && req.op == FSN_OP_CMP && cls_a.inf && !cls_b.nan && !cls_b.inf
    |=> rsp.cmp == ($past(req.a[31]) ? FSN_LT : FSN_GT))
    else $error("infinity ordered wrongly");

  chk_inf_pass: assert property (@(posedge mclk) disable iff (sys_rst)
    req_valid && req.op == FSN_OP_ADD && cls_a.inf && cls_b.norm
    |=> rsp.result == $past(req.a) && !rsp.invalid_flag)
    else $error("infinity plus finite mishandled");

  chk_indef_default: assert property (@(posedge mclk) disable iff (sys_rst)
    req_valid && req.op == FSN_OP_MUL && cls_a.inf && cls_b.zero && req.invalid_mask
    |=> rsp.result == INDEF_VALUE && rsp.invalid_flag && !rsp.trap)
    else $error("masked invalid did not give indefinite");

  // unmasked signaling source must hold the destination back
  chk_unmasked_snan: assert property (@(posedge mclk) disable iff (sys_rst)
    req_valid && !cvt && (cls_a.snan || (cls_b.snan && !unary)) && !req.invalid_mask
    |=> rsp.trap && rsp.store_suppress)
    else $error("unmasked signaling operand did not trap");

  chk_masked_no_trap: assert property (@(posedge mclk) disable iff (sys_rst)
    req_valid && req.invalid_mask |=> !rsp.trap && !rsp.store_suppress)
    else $error("masked request asked for a handler");

  // quieting touches the quiet bit only
  chk_snan_quieted: assert property (@(posedge mclk) disable iff (sys_rst)
    req_valid && req.op == FSN_OP_ADD && cls_b.snan && !cls_a.nan
    |=> rsp.result[SP_QBIT] && rsp.result[SP_QBIT-1:0] == $past(req.b[SP_QBIT-1:0])
    && rsp.result[SP_W-1:SP_QBIT+1] == $past(req.b[SP_W-1:SP_QBIT+1]))
    else $error("quieted nan lost payload bits");

  chk_unary_nan: assert property (@(posedge mclk) disable iff (sys_rst)
    req_valid && req.op == FSN_OP_SQRT && cls_a.nan
    |=> rsp.special && rsp.result == fsn_quiet_sp($past(req.a)))
    else $error("one-operand nan not returned");

  chk_legacy_larger: assert property (@(posedge mclk) disable iff (sys_rst)
    req_valid && req.style == FSN_LEGACY && req.op == FSN_OP_ADD && cls_a.nan && cls_b.nan
    && !cls_a.snan && !cls_b.snan && req.b[SP_FRAC_W-1:0] > req.a[SP_FRAC_W-1:0]
    |=> rsp.result == $past(req.b))
    else $error("legacy style did not pick larger significand");

  // overflow on ordinary operands gives a signed infinity
  chk_ovf_inf: assert property (@(posedge mclk) disable iff (sys_rst)
    req_valid && req.ovf && req.op == FSN_OP_MUL && cls_a.norm && cls_b.norm
    |=> rsp.special && rsp.result[SP_W-2:SP_FRAC_W] == SP_EXP_MAX
    && rsp.result[SP_FRAC_W-1:0] == '0
    && rsp.result[SP_W-1] == ($past(req.a[SP_W-1]) ^ $past(req.b[SP_W-1])))
    else $error("overflow did not give infinity");

  chk_normal_plain: assert property (@(posedge mclk) disable iff (sys_rst)
    req_valid && req.op == FSN_OP_ADD && cls_a.norm && cls_b.norm && !req.ovf
    |=> !rsp.special && !rsp.invalid_flag)
    else $error("ordinary operands treated as special");

  chk_half_widen: assert property (@(posedge mclk) disable iff (sys_rst)
    req_valid && req.op == FSN_OP_H2S && cls_h.inf
    |=> rsp.result == {$past(req.a[HP_W-1]), SP_EXP_MAX, {SP_FRAC_W{1'b0}}})
    else $error("half infinity widened wrongly");

  // nan compares unordered whatever its sign
  chk_nan_unordered: assert property (@(posedge mclk) disable iff (sys_rst)
    req_valid && req.op == FSN_OP_CMP && (cls_a.nan || cls_b.nan) |=> rsp.cmp == FSN_UN)
    else $error("nan compare not unordered");

endmodule : fsn_handler
`default_nettype wire

// File: fsn_pipe_model.sv
/*
  pipeline model that feeds requests to the special-value handler
  assumes the bench calls put and drop at a falling edge of mclk
*/
`timescale 1ns/1ns
`default_nettype none
module fsn_pipe_model (
  input  wire logic              mclk,
  output logic                   req_valid,
  output fsn_pkg::fsn_req_t      req,
  input  wire logic              rsp_valid,
  input  wire fsn_pkg::fsn_rsp_t rsp
);
  import fsn_pkg::*;
  // idle until the bench issues work
  initial begin
    req_valid = 1'b0;
    req       = '0;
  end
  ////////////////////////////////////////////////////////////////////////
  // present one request, take the answer one cycle later
  task automatic put(input fsn_req_t r, output logic rv, output fsn_rsp_t rs);
    req_valid = 1'b1;
    req       = r;
    @(posedge mclk);
    @(negedge mclk);
    rv = rsp_valid;
    rs = rsp;
  endtask : put
  // released operands must not keep their last value
  task automatic drop();
    req_valid = 1'b0;
    req.a     = ~req.a;
    req.b     = ~req.b;
  endtask : drop
endmodule : fsn_pipe_model
`default_nettype wire

// File: fsn_handler_test.sv
/*
  self-checking bench of the special-value and nan handler
  assumes fsn_pkg, the handler and the pipeline model are compiled first
*/
`timescale 1ns/1ns
`default_nettype none
module fsn_handler_test;
  import fsn_pkg::*;
  logic     mclk;
  logic     sys_rst;
  logic     req_valid;
  fsn_req_t req;
  logic     rsp_valid;
  fsn_rsp_t rsp;
  int       err_total;
  int       n_tests;
  logic     v;
  fsn_rsp_t s;

  // 100 MHz clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  fsn_handler dut (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .req_valid (req_valid),
    .req       (req),
    .rsp_valid (rsp_valid),
    .rsp       (rsp)
  );

  fsn_pipe_model pipe (
    .mclk      (mclk),
    .req_valid (req_valid),
    .req       (req),
    .rsp_valid (rsp_valid),
    .rsp       (rsp)
  );

  ////////////////////////////////////////////////////////////////////////
  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      err_total++;
    end
  endtask : chk

  function automatic logic [31:0] fl(input fsn_rsp_t x);
    fl = {28'h0, x.invalid_flag, x.trap, x.store_suppress, x.inexact};
  endfunction : fl

  function automatic fsn_req_t mk(input fsn_op_t op, input fsn_style_t st,
                                  input logic m, input logic [31:0] a,
                                  input logic [31:0] b);
    mk = '{op: op, style: st, invalid_mask: m, ovf: 1'b0, core_inexact: 1'b0,
           a: a, b: b};
  endfunction : mk

  // one transfer; sel[1] checks result, sel[0] checks flags
  task automatic go(input fsn_req_t r, input logic [31:0] exp,
                    input logic [31:0] f, input logic [1:0] sel);
    pipe.put(r, v, s);
    chk({31'h0, v}, 32'h1);
    if (sel[1]) begin
      chk(s.result, exp);
    end
    if (sel[0]) begin
      chk(fl(s), f);
    end
  endtask : go

  // release the request, answer must not stay valid
  task automatic idle_chk(input string name);
    pipe.drop();
    @(negedge mclk);
    chk({31'h0, rsp_valid}, 32'h0);
    chk(fl(rsp), 32'h0);
    $display("test %s done", name);
  endtask : idle_chk

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    chk({31'h0, rsp_valid}, 32'h0);
    chk(rsp.result, 32'h0);
    sys_rst = 1'b0;
    @(negedge mclk);
    chk({31'h0, rsp_valid}, 32'h0);
    chk(fl(rsp), 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_inf();
    fsn_req_t r;
    r = mk(FSN_OP_ADD, FSN_LEGACY, 1'b1, 32'h7f800000, 32'h3f800000);
    r.core_inexact = 1'b1;
    go(r, 32'h7f800000, 32'h0, 2'b11);
    chk({31'h0, s.special}, 32'h1);
    r = mk(FSN_OP_MUL, FSN_LEGACY, 1'b1, 32'h7f800000, 32'h0);
    go(r, SP_INDEF_DEF, 32'h8, 2'b11);
    r = mk(FSN_OP_SUB, FSN_LEGACY, 1'b1, 32'h7f800000, 32'h7f800000);
    go(r, SP_INDEF_DEF, 32'h8, 2'b11);
    r = mk(FSN_OP_DIV, FSN_VECTOR, 1'b1, 32'h3f800000, 32'hff800000);
    go(r, 32'h80000000, 32'h0, 2'b11);
    r = mk(FSN_OP_DIV, FSN_LEGACY, 1'b1, 32'h00000000, 32'h80000000);
    go(r, SP_INDEF_DEF, 32'h8, 2'b11);
    r = mk(FSN_OP_ADD, FSN_VECTOR, 1'b0, 32'h7f800000, 32'hff800000);
    go(r, 32'h0, 32'he, 2'b01);
    r = mk(FSN_OP_MUL, FSN_LEGACY, 1'b1, 32'hbf800000, 32'h3f800000);
    r.ovf = 1'b1;
    go(r, 32'hff800000, 32'h0, 2'b10);
    idle_chk("infinity");
  endtask : t_inf

  task automatic gc(input logic [31:0] a, input logic [31:0] b,
                    input fsn_cmp_t c);
    go(mk(FSN_OP_CMP, FSN_LEGACY, 1'b1, a, b), 32'h0, 32'h0, 2'b01);
    chk({30'h0, s.cmp}, {30'h0, c});
  endtask : gc

  task automatic t_cmp();
    gc(32'hff800000, 32'hff7fffff, FSN_LT);
    gc(32'h7f800000, 32'h7f7fffff, FSN_GT);
    gc(32'h7f7fffff, 32'h7f800000, FSN_LT);
    gc(32'h7fc00000, 32'h3f800000, FSN_UN);
    idle_chk("compare");
  endtask : t_cmp

  // back-to-back nan pairs and nan with ordinary value, both styles
  task automatic t_nan();
    logic [31:0] ta [8] = '{32'h7f800001, 32'h7f800001, 32'h7f800001, 32'h7f800001,
                            32'h7fc00001, 32'h7fc00001, 32'h3f800000, 32'h7fc00007};
    logic [31:0] tb [8] = '{32'h7fc00002, 32'h7fc00002, 32'h7f800005, 32'h7f800005,
                            32'hffc00003, 32'hffc00003, 32'hff800010, 32'h3f800000};
    logic [31:0] te [8] = '{32'h7fc00002, 32'h7fc00001, 32'h7fc00005, 32'h7fc00001,
                            32'hffc00003, 32'h7fc00001, 32'hffc00010, 32'h7fc00007};
    logic [7:0]  ts = 8'h6a;
    logic [7:0]  ti = 8'h4f;
    for (int i = 0; i < 8; i++) begin
      go(mk(FSN_OP_ADD, fsn_style_t'(ts[i]), 1'b1, ta[i], tb[i]), te[i],
         {28'h0, ti[i], 3'h0}, 2'b11);
    end
    idle_chk("nan table");
  endtask : t_nan

  task automatic t_unmasked();
    go(mk(FSN_OP_ADD, FSN_VECTOR, 1'b0, 32'h7f800001, 32'h3f800000), 32'h0, 32'he,
       2'b01);
    go(mk(FSN_OP_ADD, FSN_VECTOR, 1'b0, 32'h7fc00000, 32'h3f800000), 32'h7fc00000,
       32'h0, 2'b11);
    idle_chk("unmasked");
  endtask : t_unmasked

  task automatic t_unary();
    go(mk(FSN_OP_SQRT, FSN_LEGACY, 1'b1, 32'hff800123, 32'h0), 32'hffc00123, 32'h8,
       2'b11);
    go(mk(FSN_OP_SQRT, FSN_LEGACY, 1'b1, 32'h7fc00009, 32'h0), 32'h7fc00009, 32'h0,
       2'b11);
    go(mk(FSN_OP_SQRT, FSN_VECTOR, 1'b1, 32'hbf800000, 32'h0), SP_INDEF_DEF, 32'h8,
       2'b11);
    go(mk(FSN_OP_S2H, FSN_VECTOR, 1'b1, 32'h7fa02000, 32'h0), 32'h00007f01, 32'h0,
       2'b10);
    go(mk(FSN_OP_H2S, FSN_VECTOR, 1'b1, 32'h00007d01, 32'h0), 32'h7fe02000, 32'h0,
       2'b10);
    go(mk(FSN_OP_H2S, FSN_VECTOR, 1'b1, 32'h0000fc00, 32'h0), 32'hff800000, 32'h0,
       2'b11);
    idle_chk("one operand");
  endtask : t_unary

  task automatic t_norm();
    fsn_req_t r;
    r = mk(FSN_OP_ADD, FSN_LEGACY, 1'b1, 32'h3f800000, 32'h33800000);
    r.core_inexact = 1'b1;
    go(r, 32'h0, 32'h1, 2'b01);
    chk({31'h0, s.special}, 32'h0);
    go(mk(FSN_OP_ADD, FSN_LEGACY, 1'b1, 32'h7f7fffff, 32'h00800000), 32'h0, 32'h0,
       2'b01);
    chk({31'h0, s.special}, 32'h0);
    go(mk(FSN_OP_MUL, FSN_LEGACY, 1'b1, 32'h00000001, 32'h3f800000), 32'h0, 32'h0,
       2'b01);
    chk({31'h0, s.special}, 32'h0);
    idle_chk("ordinary");
  endtask : t_norm

  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up

  // main sequence
  initial begin
    err_total = 0;
    n_tests   = 0;
    sys_rst   = 1'b1;
    t_reset();
    @(negedge mclk);
    t_inf();
    t_cmp();
    t_nan();
    t_unmasked();
    t_unary();
    t_norm();
    wrap_up();
  end

  // hang guard
  initial begin
    repeat (5000) @(posedge mclk);
    err_total++;
    wrap_up();
  end
endmodule : fsn_handler_test
`default_nettype wire
